// [pkg/rtmc_map.vh]
// Purpose: Register offsets, field positions, reset values and codes for the
//          remote terminal mode command handler.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte addresses on the AXI4-Lite register port, one word each.
`ifndef RTMC_MAP_VH
`define RTMC_MAP_VH

// Plain registers (byte offsets, region 0x000)
`define RTMC_OFF_CTRL 8'h00
`define RTMC_OFF_PEND 8'h04
`define RTMC_OFF_BITW0 8'h08
`define RTMC_OFF_BITW1 8'h0C
`define RTMC_OFF_ILL_RX_NB 8'h10
`define RTMC_OFF_ILL_TX_NB 8'h14
`define RTMC_OFF_ILL_RX_BC 8'h18
`define RTMC_OFF_ILL_TX_BC 8'h1C
`define RTMC_OFF_STATUS 8'h20
`define RTMC_OFF_LASTCMD 8'h24

// Table regions, selected by address bits 11:8
`define RTMC_RGN_REGS 4'h0
`define RTMC_RGN_DCTRL 4'h1
`define RTMC_RGN_DDATA 4'h2
`define RTMC_RGN_INFO 4'h3
`define RTMC_RGN_BUF0 4'h4
`define RTMC_RGN_BUF1 4'h5

// Control register fields
`define RTMC_CTRL_UNDEF_INV 0
`define RTMC_CTRL_SIMPLIFIED_MODE_STORAGE_EN 1
`define RTMC_CTRL_ALTBIT 2
`define RTMC_CTRL_IWA_EN 3
`define RTMC_CTRL_IBR_EN 4
`define RTMC_CTRL_RST 32'h0000_0000

// Descriptor control word fields (4 bits per mode command)
`define RTMC_DC_IWA 3
`define RTMC_DC_IBR 2
`define RTMC_DC_CIRC 1
`define RTMC_DC_PINGPONG 0

// Pending interrupt bits
`define RTMC_PEND_IWA 0
`define RTMC_PEND_IBR 1

// Status word fields
`define RTMC_ST_ME 10
`define RTMC_ST_DBCA 1

// Message information word fields
`define RTMC_MI_BCAST 0
`define RTMC_MI_ME 1
`define RTMC_MI_DBAC 2

// Interrupt information word: type bits for interrupt when accessed and for interrupt on broadcast received
`define RTMC_IIW_IWA 16'h0001
`define RTMC_IIW_IBR 16'h0002

// Descriptor table base of the mode command half, in words
`define RTMC_DESC_BASE 16'h0200

// AXI response codes
`define RTMC_RESP_OKAY 2'b00
`define RTMC_RESP_SLVERR 2'b10

`endif

// [hdl/rtmc_core.v]
// Purpose: Mode command decode, response and interrupt logging for a
//          MIL-STD-1553 remote terminal, with an AXI4-Lite register port.
// Assumes: Command words arrive already address-matched, one pulse per word,
//          with the receive mode data word on cmd_data_i in the same cycle.
// Notes:   Answer to a command appears one cycle after cmd_valid_i.
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_map.vh"

module rtmc_core #(
   parameter ADDR_W = 12
) (
   // Clock and reset
   input wire clock_i,
   input wire rst_i,
   // AXI4-Lite write address and data
   input wire [ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output reg s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output reg s_axi_wready_o,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   // AXI4-Lite read
   input wire [ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output reg s_axi_arready_o,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // Received command side
   input wire cmd_valid_i,
   input wire [15:0] cmd_word_i,
   input wire cmd_bcast_i,
   input wire [15:0] cmd_data_i,
   input wire [4:0] rt_addr_i,
   input wire [15:0] time_tag_i,
   // Response side
   output reg resp_valid_o,
   output reg resp_send_status_o,
   output reg resp_send_data_o,
   output reg [15:0] resp_status_o,
   output reg [15:0] resp_data_o,
   output reg rx_take_o,
   // Interrupt log and message interrupt
   output reg log_wr_o,
   output reg [15:0] irq_info_word_o,
   output reg [15:0] irq_address_word_o,
   output reg message_irq_n_o
);

   // Software state
   reg [31:0] ctrl_q; // Global option bits
   reg [1:0] pend_q; // Pending interrupt bits
   reg [15:0] bitw0_q; // Built-in test word, normal
   reg [15:0] bitw1_q; // Built-in test word, alternate
   reg [31:0] ill_rx_nb_q; // Illegal table, receive, non-broadcast
   reg [31:0] ill_tx_nb_q; // Illegal table, transmit, non-broadcast
   reg [31:0] ill_rx_bc_q; // Illegal table, receive, broadcast
   reg [31:0] ill_tx_bc_q; // Illegal table, transmit, broadcast
   reg [3:0] dctrl_q [0:63]; // Descriptor control bits per command
   reg [15:0] ddata_q [0:63]; // Descriptor word 4 (simplified storage)
   reg [31:0] info_q [0:63]; // Time tag in 31:16, message info in 15:0
   reg [15:0] buf_q [0:127]; // Indexed / ping-pong data buffers
   reg [63:0] page_q; // Ping-pong page per command
   // Terminal state
   reg [15:0] status_q; // Last status word
   reg [15:0] last_cmd_q; // Last command word
   reg [1:0] irq_cause_q; // Interrupt causes waiting to set the pending bits
   // AXI internal
   reg [ADDR_W-1:0] aw_addr_q; // Captured write address
   reg aw_full_q; // Write address held
   reg [31:0] w_data_q; // Captured write data
   reg [3:0] w_strb_q; // Captured strobes
   reg w_full_q; // Write data held
   integer i;

   // Byte-lane merge for register writes
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] strb;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            merge[k*8 +: 8] = strb[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
         end
      end
   endfunction

   // Command fields
   wire [4:0] code = cmd_word_i[4:0];
   wire tr = cmd_word_i[10];
   wire [4:0] sa = cmd_word_i[9:5];
   wire [5:0] idx = {tr, code}; // Descriptor index per code and direction
   wire is_mode = (sa == 5'h00) || (sa == 5'h1F);
   wire has_data = code[4];
   // The 22 undefined commands
   wire undef = (!tr && !code[4]) ||
                (!tr && (code == 5'd16 || code == 5'd18 || code == 5'd19)) ||
                (tr && (code == 5'd17 || code == 5'd20 || code == 5'd21));
   wire invalid = undef && ctrl_q[`RTMC_CTRL_UNDEF_INV];
   // Broadcast permission table
   wire bc_ok = (tr && (code == 5'd1 || (code >= 5'd3 && code <= 5'd15))) ||
                (!tr && (code == 5'd17 || code == 5'd20 || code == 5'd21 ||
                 code >= 5'd22));
   // Illegalization bit; reserved codes rely on this alone
   wire [31:0] ill_row = cmd_bcast_i ? (tr ? ill_tx_bc_q : ill_rx_bc_q) :
                                       (tr ? ill_tx_nb_q : ill_rx_nb_q);
   wire illegal = ill_row[code] || (cmd_bcast_i && !bc_ok);
   wire hit = cmd_valid_i && is_mode && !invalid;
   wire simpl = ctrl_q[`RTMC_CTRL_SIMPLIFIED_MODE_STORAGE_EN];
   wire [3:0] dc = dctrl_q[idx];
   wire pg = page_q[idx] & dc[`RTMC_DC_PINGPONG]; // Circular bit ignored
   wire is_tx_status = tr && (code == 5'd2);
   wire is_tx_last = tr && (code == 5'd18);
   wire is_tx_bit = tr && (code == 5'd19);
   // Data word moves only for legal codes 16-31
   wire moves_data = has_data && !illegal;
   wire rx_store = hit && !tr && moves_data;
   wire tx_send = hit && tr && moves_data && !cmd_bcast_i;

   // Transmit data source
   reg [15:0] tx_word;
   always @* begin
      if (is_tx_last) begin
         tx_word = last_cmd_q;
      end else if (is_tx_bit) begin
         tx_word = ctrl_q[`RTMC_CTRL_ALTBIT] ? bitw1_q : bitw0_q;
      end else if (simpl) begin
         tx_word = ddata_q[idx];
      end else begin
         tx_word = buf_q[{idx, pg}];
      end
   end

   // New status: message error from illegality, acceptance bit never set
   wire [15:0] new_status = {rt_addr_i, illegal, 8'h00, 1'b0, 1'b0};
   // Legal status-reporting commands answer with the previous status
   wire keep_status = (is_tx_status || is_tx_last) && !illegal;
   wire [15:0] out_status = keep_status ? status_q : new_status;
   // Interrupt causes: broadcast interrupt only for codes 0-15
   wire iwa_cause = dc[`RTMC_DC_IWA] && ctrl_q[`RTMC_CTRL_IWA_EN];
   wire ibr_cause = dc[`RTMC_DC_IBR] && cmd_bcast_i && !code[4] &&
                    ctrl_q[`RTMC_CTRL_IBR_EN];
   // Stored word after a data transfer, also copies automatic words
   wire store_word = rx_store || (hit && tr && moves_data && (is_tx_last || is_tx_bit));
   wire [15:0] store_val = tr ? tx_word : cmd_data_i;
   wire [15:0] msg_info = {13'h0000, 1'b1, illegal, cmd_bcast_i};

   // Response outputs, one cycle after the command
   always @(posedge clock_i) begin
      if (rst_i) begin
         resp_valid_o <= 1'b0;
         resp_send_status_o <= 1'b0;
         resp_send_data_o <= 1'b0;
         resp_status_o <= 16'h0000;
         resp_data_o <= 16'h0000;
         rx_take_o <= 1'b0;
         status_q <= 16'h0000;
         last_cmd_q <= 16'h0000;
      end else begin
         resp_valid_o <= hit; // Ignored commands leave no trace
         resp_send_status_o <= hit && !cmd_bcast_i;
         resp_send_data_o <= tx_send;
         rx_take_o <= rx_store;
         if (hit) begin
            resp_status_o <= out_status;
            resp_data_o <= tx_send ? tx_word : 16'h0000;
            if (!keep_status) begin
               status_q <= new_status;
            end
            if (!(is_tx_last && !illegal)) begin
               last_cmd_q <= cmd_word_i; // Last command tracks valid commands except a legal transmit last command
            end
         end
      end
   end

   // Page flip for accepted commands with the ping-pong bit set, simplified storage off
   always @(posedge clock_i) begin
      if (rst_i) begin
         page_q <= 64'h0000_0000_0000_0000;
      end else if (hit && dc[`RTMC_DC_PINGPONG] && !simpl) begin
         page_q[idx] <= ~page_q[idx];
      end
   end

   // Info words: written only by the terminal, codes 0-15 store no data word
   always @(posedge clock_i) begin
      if (rst_i) begin
         for (i = 0; i < 64; i = i + 1) begin
            info_q[i] <= 32'h0000_0000;
         end
      end else if (hit) begin
         info_q[idx] <= {time_tag_i, msg_info};
      end
   end

   // Interrupt log, then pending bits and interrupt one cycle later
   wire pend_wr = w_full_q && aw_full_q && !s_axi_bvalid_o &&
                  aw_addr_q[11:8] == `RTMC_RGN_REGS && aw_addr_q[7:0] == `RTMC_OFF_PEND;
   wire [1:0] pend_clr = pend_wr ? w_data_q[1:0] : 2'b00;
   wire [1:0] pend_d = (pend_q & ~pend_clr) | irq_cause_q; // Set wins over clear
   always @(posedge clock_i) begin
      if (rst_i) begin
         irq_cause_q <= 2'b00;
         pend_q <= 2'b00;
         log_wr_o <= 1'b0;
         irq_info_word_o <= 16'h0000;
         irq_address_word_o <= 16'h0000;
         message_irq_n_o <= 1'b1;
      end else begin
         irq_cause_q <= hit ? {ibr_cause, iwa_cause} : 2'b00;
         log_wr_o <= hit && (iwa_cause || ibr_cause);
         if (hit && (iwa_cause || ibr_cause)) begin
            irq_info_word_o <= (iwa_cause ? `RTMC_IIW_IWA : 16'h0000) |
                               (ibr_cause ? `RTMC_IIW_IBR : 16'h0000);
            irq_address_word_o <= `RTMC_DESC_BASE | {8'h00, idx, 2'b00};
         end
         pend_q <= pend_d;
         message_irq_n_o <= ~(|pend_d); // Low while anything pends
      end
   end

   // AXI write channel capture; address and data taken in either order
   wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid_o;
   wire [3:0] wr_rgn = aw_addr_q[11:8];
   wire [7:0] wr_off = aw_addr_q[7:0];
   reg wr_err;
   always @* begin
      wr_err = 1'b0;
      case (wr_rgn)
         `RTMC_RGN_REGS: begin
            case (wr_off)
               `RTMC_OFF_CTRL, `RTMC_OFF_PEND, `RTMC_OFF_BITW0, `RTMC_OFF_BITW1,
               `RTMC_OFF_ILL_RX_NB, `RTMC_OFF_ILL_TX_NB, `RTMC_OFF_ILL_RX_BC,
               `RTMC_OFF_ILL_TX_BC, `RTMC_OFF_STATUS, `RTMC_OFF_LASTCMD: wr_err = 1'b0;
               default: wr_err = 1'b1;
            endcase
         end
         `RTMC_RGN_DCTRL, `RTMC_RGN_DDATA, `RTMC_RGN_INFO,
         `RTMC_RGN_BUF0, `RTMC_RGN_BUF1: wr_err = 1'b0;
         default: wr_err = 1'b1;
      endcase
   end

   always @(posedge clock_i) begin
      if (rst_i) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `RTMC_RESP_OKAY;
      end else begin
         // Ready only while the holding slot is empty
         s_axi_awready_o <= !aw_full_q && !(s_axi_awvalid_i && s_axi_awready_o);
         s_axi_wready_o <= !w_full_q && !(s_axi_wvalid_i && s_axi_wready_o);
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_addr_q <= s_axi_awaddr_i;
            aw_full_q <= 1'b1;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_data_q <= s_axi_wdata_i;
            w_strb_q <= s_axi_wstrb_i;
            w_full_q <= 1'b1;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_err ? `RTMC_RESP_SLVERR : `RTMC_RESP_OKAY;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // Plain register writes; status and last command are read only
   wire [31:0] wr_b0 = merge({16'h0000, bitw0_q}, w_data_q, w_strb_q);
   wire [31:0] wr_b1 = merge({16'h0000, bitw1_q}, w_data_q, w_strb_q);
   always @(posedge clock_i) begin
      if (rst_i) begin
         ctrl_q <= `RTMC_CTRL_RST; // Undefined codes valid after reset
         bitw0_q <= 16'h0000;
         bitw1_q <= 16'h0000;
         ill_rx_nb_q <= 32'h0000_0000; // All legal after reset
         ill_tx_nb_q <= 32'h0000_0000;
         ill_rx_bc_q <= 32'h0000_0000;
         ill_tx_bc_q <= 32'h0000_0000;
      end else if (wr_go && wr_rgn == `RTMC_RGN_REGS) begin
         case (wr_off)
            `RTMC_OFF_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_001F;
            `RTMC_OFF_BITW0: bitw0_q <= wr_b0[15:0];
            `RTMC_OFF_BITW1: bitw1_q <= wr_b1[15:0];
            `RTMC_OFF_ILL_RX_NB: ill_rx_nb_q <= merge(ill_rx_nb_q, w_data_q, w_strb_q);
            `RTMC_OFF_ILL_TX_NB: ill_tx_nb_q <= merge(ill_tx_nb_q, w_data_q, w_strb_q);
            `RTMC_OFF_ILL_RX_BC: ill_rx_bc_q <= merge(ill_rx_bc_q, w_data_q, w_strb_q);
            `RTMC_OFF_ILL_TX_BC: ill_tx_bc_q <= merge(ill_tx_bc_q, w_data_q, w_strb_q);
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Descriptor control words, host written only
   wire [31:0] wr_dc = merge({28'h000_0000, dctrl_q[wr_off[7:2]]}, w_data_q, w_strb_q);
   always @(posedge clock_i) begin
      if (rst_i) begin
         for (i = 0; i < 64; i = i + 1) begin
            dctrl_q[i] <= 4'h0;
         end
      end else if (wr_go && wr_rgn == `RTMC_RGN_DCTRL) begin
         dctrl_q[wr_off[7:2]] <= wr_dc[3:0];
      end
   end

   // Descriptor data words; the terminal's own store wins a collision
   wire [31:0] wr_dd = merge({16'h0000, ddata_q[wr_off[7:2]]}, w_data_q, w_strb_q);
   always @(posedge clock_i) begin
      if (store_word && simpl) begin
         ddata_q[idx] <= store_val;
      end else if (wr_go && wr_rgn == `RTMC_RGN_DDATA) begin
         ddata_q[wr_off[7:2]] <= wr_dd[15:0];
      end
   end

   // Buffer words; two regions hold page 0 and page 1
   wire [6:0] wr_bi = {wr_off[7:2], wr_rgn[0]};
   wire [31:0] wr_bf = merge({16'h0000, buf_q[wr_bi]}, w_data_q, w_strb_q);
   always @(posedge clock_i) begin
      if (store_word && !simpl) begin
         buf_q[{idx, pg}] <= store_val;
      end else if (wr_go && (wr_rgn == `RTMC_RGN_BUF0 || wr_rgn == `RTMC_RGN_BUF1)) begin
         buf_q[wr_bi] <= wr_bf[15:0];
      end
   end

   // Read data mux; unmapped addresses answer SLVERR with zero
   wire [3:0] rd_rgn = s_axi_araddr_i[11:8];
   wire [7:0] rd_off = s_axi_araddr_i[7:0];
   reg [31:0] rd_data;
   reg rd_err;
   always @* begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      case (rd_rgn)
         `RTMC_RGN_REGS: begin
            case (rd_off)
               `RTMC_OFF_CTRL: rd_data = ctrl_q;
               `RTMC_OFF_PEND: rd_data = {30'h0000_0000, pend_q};
               `RTMC_OFF_BITW0: rd_data = {16'h0000, bitw0_q};
               `RTMC_OFF_BITW1: rd_data = {16'h0000, bitw1_q};
               `RTMC_OFF_ILL_RX_NB: rd_data = ill_rx_nb_q;
               `RTMC_OFF_ILL_TX_NB: rd_data = ill_tx_nb_q;
               `RTMC_OFF_ILL_RX_BC: rd_data = ill_rx_bc_q;
               `RTMC_OFF_ILL_TX_BC: rd_data = ill_tx_bc_q;
               `RTMC_OFF_STATUS: rd_data = {16'h0000, status_q};
               `RTMC_OFF_LASTCMD: rd_data = {16'h0000, last_cmd_q};
               default: rd_err = 1'b1;
            endcase
         end
         `RTMC_RGN_DCTRL: rd_data = {28'h000_0000, dctrl_q[rd_off[7:2]]};
         `RTMC_RGN_DDATA: rd_data = {16'h0000, ddata_q[rd_off[7:2]]};
         `RTMC_RGN_INFO: rd_data = info_q[rd_off[7:2]];
         `RTMC_RGN_BUF0, `RTMC_RGN_BUF1: rd_data = {16'h0000, buf_q[{rd_off[7:2], rd_rgn[0]}]};
         default: rd_err = 1'b1;
      endcase
   end

   // Read channel: one read at a time, data registered
   always @(posedge clock_i) begin
      if (rst_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= `RTMC_RESP_OKAY;
      end else begin
         s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_data;
            s_axi_rresp_o <= rd_err ? `RTMC_RESP_SLVERR : `RTMC_RESP_OKAY;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

endmodule // rtmc_core
`default_nettype wire

// [verification/rtmc_sva.sv]
// Purpose: Port checks for the mode command handler
// Assumes: Bound to rtmc_core, one cycle answer per command
// Notes: Watches the command inputs and what the core drives
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_map.vh"
module rtmc_sva (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Command side
   input wire logic cmd_valid_i,
   input wire logic [15:0] cmd_word_i,
   input wire logic cmd_bcast_i,
   // Answer and log side
   input wire logic resp_valid_o,
   input wire logic resp_send_status_o,
   input wire logic resp_send_data_o,
   input wire logic [15:0] resp_status_o,
   input wire logic rx_take_o,
   input wire logic log_wr_o,
   input wire logic [15:0] irq_info_word_o,
   input wire logic [15:0] irq_address_word_o,
   input wire logic message_irq_n_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // Subaddress all zeros or all ones marks a mode command
   wire mode_w = cmd_word_i[9:5] == 5'h00 || cmd_word_i[9:5] == 5'h1F;
   // Log entry lands one cycle ahead of the interrupt
   sequence s_log_irq;
      log_wr_o ##1 !message_irq_n_o;
   endsequence
   property p_dbca; resp_status_o[`RTMC_ST_DBCA] == 1'h0; endproperty
   a_dbca: assert property (p_dbca) else $error("bus control bit set");
   property p_bc; cmd_valid_i && cmd_bcast_i |=> !resp_send_status_o && !resp_send_data_o;
   endproperty
   a_bc: assert property (p_bc) else $error("broadcast answered");
   property p_nodat; cmd_valid_i && mode_w && !cmd_word_i[4] |=> !resp_send_data_o && !rx_take_o;
   endproperty
   a_nodat: assert property (p_nodat) else $error("data on low code");
   property p_nomode; cmd_valid_i && !mode_w |=> !resp_valid_o; endproperty
   a_nomode: assert property (p_nomode) else $error("non-mode accepted");
   property p_txd; resp_send_data_o |-> resp_send_status_o && $past(cmd_word_i[10] & cmd_word_i[4]);
   endproperty
   a_txd: assert property (p_txd) else $error("stray transmit data");
   property p_rxd; rx_take_o |-> resp_valid_o && $past(!cmd_word_i[10] & cmd_word_i[4]); endproperty
   a_rxd: assert property (p_rxd) else $error("stray receive data");
   // Transmit last command echoes an older status, so it is left out
   property p_me; resp_valid_o && resp_status_o[`RTMC_ST_ME] && $past(cmd_word_i[4:0]) != 5'h12
      |-> !resp_send_data_o && !rx_take_o; endproperty
   a_me: assert property (p_me) else $error("data moved when illegal");
   property p_log; log_wr_o |-> s_log_irq; endproperty
   a_log: assert property (p_log) else $error("no interrupt after log");
   property p_fell; $fell(message_irq_n_o) |-> $past(log_wr_o); endproperty
   a_fell: assert property (p_fell) else $error("interrupt before log");
   property p_iaw; log_wr_o |-> irq_address_word_o == (`RTMC_DESC_BASE |
      {8'h00, $past(cmd_word_i[10]), $past(cmd_word_i[4:0]), 2'h0}); endproperty
   a_iaw: assert property (p_iaw) else $error("bad address word");
   property p_iiw; log_wr_o && !$past(cmd_bcast_i) |-> irq_info_word_o == `RTMC_IIW_IWA; endproperty
   a_iiw: assert property (p_iiw) else $error("bad info word");
endmodule // rtmc_sva
`default_nettype wire

// [verification/rtmc_bc_model.sv]
// Purpose: Bus controller stand-in issuing mode commands
// Assumes: Words arrive address-matched, one pulse each
// Notes: Unused data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module rtmc_bc_model #(
   parameter logic [4:0] RT_ADDR = 5'h05
) (
   // Clock
   input wire logic clock_i,
   // Command stream
   output var logic cmd_valid_o,
   output var logic [15:0] cmd_word_o,
   output var logic cmd_bcast_o,
   output var logic [15:0] cmd_data_o
);
   // Quiet at time zero
   initial begin
      {cmd_valid_o, cmd_bcast_o, cmd_word_o, cmd_data_o} = '0;
   end
   // One pulse; a data word only with receive codes 16-31, else a moving pattern
   task automatic send(input logic [4:0] sa, input logic tr, input logic [4:0] c,
      input logic bc, input logic [15:0] d);
      @(posedge clock_i);
      cmd_word_o <= {bc ? 5'h1F : RT_ADDR, tr, sa, c};
      cmd_bcast_o <= bc;
      cmd_valid_o <= 1'h1;
      cmd_data_o <= (!tr && c[4]) ? d : ~cmd_data_o;
      @(posedge clock_i);
      cmd_valid_o <= 1'h0;
      cmd_bcast_o <= 1'h0;
      cmd_data_o <= ~cmd_data_o;
   endtask
endmodule // rtmc_bc_model
`default_nettype wire

// [verification/testbench.sv]
// Purpose: Self-checking bench for the mode command handler
// Assumes: AXI4-Lite host, one cycle command answer
// Notes: Table rows for plain cases, hand tests after
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_map.vh"
module testbench;
   typedef struct packed {
      logic inv; logic [4:0] sa; logic tr; logic [4:0] c; logic bc; logic ill; logic [4:0] e;
   } rtmc_row_t;
   logic clock_i = 1'h0;
   logic rst_i = 1'h1;
   logic [11:0] awaddr = 12'h0;
   logic [11:0] araddr = 12'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0, rd;
   logic [1:0] rr;
   wire awready, wready, bvalid, arready, rvalid, cv, cb, rv, rs, sd, tk, lw, irqn;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] cw, cd, st, dat, irq_info_word, irq_address_word;
   int n_fail = 0, compares = 0, cyc = 0;
   // Expected flags: valid, status, data sent, data taken, message error
   rtmc_row_t rows [0:13] = '{
      '{1'h0, 5'h00, 1'h0, 5'h05, 1'h0, 1'h0, 5'h18}, '{1'h1, 5'h00, 1'h0, 5'h05, 1'h0, 1'h0, 5'h00},
      '{1'h1, 5'h00, 1'h1, 5'h11, 1'h0, 1'h0, 5'h00}, '{1'h1, 5'h00, 1'h1, 5'h01, 1'h0, 1'h0, 5'h18},
      '{1'h1, 5'h00, 1'h1, 5'h10, 1'h0, 1'h0, 5'h1C}, '{1'h0, 5'h00, 1'h1, 5'h14, 1'h0, 1'h0, 5'h1C},
      '{1'h0, 5'h00, 1'h0, 5'h12, 1'h0, 1'h0, 5'h1A}, '{1'h0, 5'h00, 1'h1, 5'h19, 1'h0, 1'h1, 5'h19},
      '{1'h0, 5'h00, 1'h0, 5'h1E, 1'h0, 1'h0, 5'h1A}, '{1'h0, 5'h00, 1'h0, 5'h11, 1'h1, 1'h0, 5'h12},
      '{1'h0, 5'h00, 1'h1, 5'h10, 1'h1, 1'h0, 5'h11}, '{1'h0, 5'h03, 1'h0, 5'h03, 1'h0, 1'h0, 5'h00},
      '{1'h0, 5'h1F, 1'h1, 5'h0C, 1'h0, 1'h1, 5'h19}, '{1'h0, 5'h00, 1'h0, 5'h16, 1'h0, 1'h1, 5'h19}};
   rtmc_core dut (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .cmd_valid_i(cv), .cmd_word_i(cw), .cmd_bcast_i(cb),
      .cmd_data_i(cd), .rt_addr_i(5'h05), .time_tag_i(cyc[15:0]), .resp_valid_o(rv),
      .resp_send_status_o(rs), .resp_send_data_o(sd), .resp_status_o(st), .resp_data_o(dat),
      .rx_take_o(tk), .log_wr_o(lw), .irq_info_word_o(irq_info_word), .irq_address_word_o(irq_address_word),
      .message_irq_n_o(irqn));
   rtmc_bc_model bcm (.clock_i(clock_i), .cmd_valid_o(cv), .cmd_word_o(cw),
      .cmd_bcast_o(cb), .cmd_data_o(cd));
   // 100 MHz clock
   always #5 clock_i = ~clock_i;
   // Hang guard, far beyond the few hundred cycles the run needs
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // Address and data offered together, each dropped when taken
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clock_i);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
   endtask
   task automatic axr(input logic [11:0] a);
      @(posedge clock_i);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clock_i);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid);
      rd = rdata;
      rr = rresp;
      rready <= 1'h0;
   endtask
   // Command; look just after the answering edge
   task automatic cmd(input logic [4:0] sa, input logic tr, input logic [4:0] c, input logic bc,
      input logic [15:0] d);
      bcm.send(sa, tr, c, bc, d);
      #1;
   endtask
   task automatic final_report();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      rtmc_row_t r;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'h0;
      for (int k = 0; k < 5; k++) begin
         axr(k == 0 ? 12'h0 : 12'h00C + 12'(4 * k));
         chk(rd, 32'h0);
      end
      axr(12'hF00);
      chk(rr, `RTMC_RESP_SLVERR);
      foreach (rows[i]) begin
         r = rows[i];
         axw(`RTMC_OFF_CTRL, {31'h0, r.inv});
         axw(`RTMC_OFF_ILL_RX_NB + {r.bc, r.tr, 2'h0}, r.ill ? 32'h1 << r.c : 32'h0);
         cmd(r.sa, r.tr, r.c, r.bc, 16'h5A5A);
         chk({rv, rs, sd, tk, st[10] & rv}, r.e);
      end
      // Transmit word from descriptor or buffer; circular request ignored
      axw(12'h2C0, 32'h1111);
      axw(12'h4C0, 32'h2222);
      axw(12'h1C0, 32'h2);
      for (int s = 0; s < 2; s++) begin
         axw(`RTMC_OFF_CTRL, 32'(s) << 1);
         cmd(5'h00, 1'h1, 5'h10, 1'h0, 16'h0);
         chk(dat, s ? 32'h1111 : 32'h2222);
         cmd(5'h00, 1'h0, 5'h14 + 5'(s), 1'h0, 16'h3C00 + 16'(s));
         axr((s ? 12'h200 : 12'h400) + 12'h050 + 12'(4 * s));
         chk(rd, 32'h3C00 + 32'(s));
      end
      // Test word chosen by option, then last command echo
      axw(`RTMC_OFF_BITW0, 32'hB0B0);
      axw(`RTMC_OFF_BITW1, 32'hB1B1);
      for (int s = 0; s < 2; s++) begin
         axw(`RTMC_OFF_CTRL, 32'(s) << 2);
         cmd(5'h00, 1'h1, 5'h13, 1'h0, 16'h0);
         chk(dat, s ? 32'hB1B1 : 32'hB0B0);
      end
      repeat (2) begin
         cmd(5'h00, 1'h1, 5'h12, 1'h0, 16'h0);
         chk(dat, 32'h2C13);
      end
      // Interrupt when accessed, enabled then masked
      axw(12'h184, 32'h8);
      for (int s = 1; s >= 0; s--) begin
         axw(`RTMC_OFF_CTRL, 32'(s) << 3);
         cmd(5'h00, 1'h1, 5'h01, 1'h0, 16'h0);
         chk(lw, 32'(s));
         if (s) chk({irq_address_word, irq_info_word}, 32'h0284_0001);
         @(posedge clock_i);
         #1;
         chk(irqn, 32'(1 - s));
         axr(`RTMC_OFF_PEND);
         chk(rd, 32'(s));
         axw(`RTMC_OFF_PEND, 32'h1);
      end
      // Ignored command keeps the error status
      axw(`RTMC_OFF_ILL_TX_NB, 32'h0200_0000);
      axw(`RTMC_OFF_CTRL, 32'h1);
      cmd(5'h00, 1'h1, 5'h19, 1'h0, 16'h0);
      cmd(5'h00, 1'h0, 5'h07, 1'h0, 16'h0);
      chk(rv, 32'h0);
      axr(`RTMC_OFF_STATUS);
      chk(rd, 32'h2C00);
      final_report();
   end
endmodule // testbench
bind rtmc_core rtmc_sva u_sva (.*);
`default_nettype wire
